// ---- hdl/dua_pkg.sv ----
// constants, register map and carrier types of the data/user memory addressing block
// assumes a 16-bit stack core and a word-wide external memory on one clock
package dua_pkg;

    // ------------------------------------------------------------
    // register map (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [2:0] DUA_OFF_IBC  = 3'h0;
    localparam logic [2:0] DUA_OFF_CFG  = 3'h1;
    localparam logic [2:0] DUA_OFF_CPR  = 3'h2;
    localparam logic [2:0] DUA_OFF_DPR  = 3'h3;
    localparam logic [2:0] DUA_OFF_IPR  = 3'h4;
    localparam logic [2:0] DUA_OFF_UPR  = 3'h5;
    localparam logic [2:0] DUA_OFF_UBR  = 3'h6;
    localparam logic [2:0] DUA_OFF_ADDR = 3'h7;

    // ------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------
    localparam int DUA_DPS_BIT   = 5;
    localparam int DUA_ORDER_BIT = 2;
    localparam int DUA_IPR_DBIT  = 4;
    localparam int DUA_PAGE_W    = 4;
    localparam int DUA_UFLD_W    = 5;
    localparam int DUA_UBASE_LO  = 6;

    localparam logic [15:0] DUA_RST_WORD = 16'h0000;
    localparam logic [3:0]  DUA_RST_PAGE = 4'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DUA_FETCH,
        DUA_DATA,
        DUA_USER
    } dua_kind_t;

    typedef struct packed {
        logic              valid;
        dua_kind_t         kind;
        logic              write;
        logic              byte_mode;
        logic [15:0]       addr;
        logic [4:0]        ufield;
        logic [15:0]       wdata;
    } dua_req_t;

    typedef struct packed {
        logic [18:0]       waddr;
        logic [15:0]       wdata;
        logic [1:0]        byte_en;
        logic              rd;
        logic              wr;
    } dua_mem_t;

    typedef struct packed {
        logic              valid;
        logic              is_byte;
        logic              odd_lane;
        logic              swap;
    } dua_pend_t;

endpackage : dua_pkg

// ---- hdl/dua_top.sv ----
// data, user and fetch address formation with byte-lane steering
// core requests arrive on CLOCK; memory read data arrive from pins
// word lane convention: bits 15:8 hold the even byte address in order mode 0, the odd one in order mode 1
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps

module dua_top #(
    parameter int MEM_LAT = 1
) (
    input  wire logic            CLOCK,
    input  wire logic            RST,
    input  wire logic [2:0]      REG_ADDR,
    input  wire logic [15:0]     REG_WDATA,
    input  wire logic            REG_WR,
    input  wire logic            REG_RD,
    output logic      [15:0]     REG_RDATA,
    input  wire dua_pkg::dua_req_t CORE_REQ,
    input  wire logic            CORE_CALL,
    input  wire logic            CORE_RET,
    input  wire logic            DPS_SET,
    input  wire logic            DPS_CLR,
    output logic      [15:0]     RD_DATA,
    output logic                 RD_VALID,
    output dua_pkg::dua_mem_t    MEM_OUT,
    input  wire logic [15:0]     MEM_RDATA
);

    localparam int PIPE_LEN = MEM_LAT + 2;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]         ibc_ff;
    logic [15:0]         cfg_ff;
    logic [3:0]          cpr_ff;
    logic [3:0]          dpr_ff;
    logic [4:0]          ipr_ff;
    logic [3:0]          upr_ff;
    logic [15:0]         ubr_ff;
    logic [19:0]         last_addr_ff;
    logic [15:0]         rdata_ff;
    dua_pkg::dua_mem_t   mem_ff;
    dua_pkg::dua_pend_t  pipe_ff [0:PIPE_LEN];
    logic [15:0]         sync1_ff;
    logic [15:0]         sync2_ff;
    logic [15:0]         rd_data_ff;
    logic                rd_valid_ff;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    wire wr_ibc = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_IBC);
    wire wr_cfg = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_CFG);
    wire wr_cpr = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_CPR);
    wire wr_dpr = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_DPR);
    wire wr_ipr = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_IPR);
    wire wr_upr = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_UPR);
    wire wr_ubr = REG_WR && (REG_ADDR == dua_pkg::DUA_OFF_UBR);

    logic [15:0] reg_sel;
    always_comb begin
        case (REG_ADDR)
            dua_pkg::DUA_OFF_IBC:  reg_sel = ibc_ff;
            dua_pkg::DUA_OFF_CFG:  reg_sel = cfg_ff;
            dua_pkg::DUA_OFF_CPR:  reg_sel = {12'h000, cpr_ff};
            dua_pkg::DUA_OFF_DPR:  reg_sel = {12'h000, dpr_ff};
            dua_pkg::DUA_OFF_IPR:  reg_sel = {11'h000, ipr_ff};
            dua_pkg::DUA_OFF_UPR:  reg_sel = {12'h000, upr_ff};
            dua_pkg::DUA_OFF_UBR:  reg_sel = ubr_ff;
            dua_pkg::DUA_OFF_ADDR: reg_sel = last_addr_ff[15:0];
            default:               reg_sel = dua_pkg::DUA_RST_WORD;
        endcase
    end

    wire [15:0] nxt_rdata = REG_RD ? reg_sel : dua_pkg::DUA_RST_WORD;

    // ------------------------------------------------------------
    // data page select and index page
    // ------------------------------------------------------------
    wire dps_now  = ibc_ff[dua_pkg::DUA_DPS_BIT];
    // return value takes effect in the same cycle
    wire dps_eff  = CORE_RET ? ipr_ff[dua_pkg::DUA_IPR_DBIT] : dps_now;

    logic nxt_dps;
    always_comb begin
        nxt_dps = dps_now;
        if (wr_ibc) begin
            nxt_dps = REG_WDATA[dua_pkg::DUA_DPS_BIT];
        end
        if (DPS_SET) begin
            nxt_dps = 1'b1;
        end else if (DPS_CLR) begin
            nxt_dps = 1'b0;
        end
        if (CORE_RET) begin
            nxt_dps = ipr_ff[dua_pkg::DUA_IPR_DBIT];
        end
    end

    logic [15:0] nxt_ibc;
    always_comb begin
        nxt_ibc = wr_ibc ? REG_WDATA : ibc_ff;
        nxt_ibc[dua_pkg::DUA_DPS_BIT] = nxt_dps;
    end

    // call saves select bit and code page for the return
    wire [4:0] nxt_ipr = CORE_CALL ? {dps_now, cpr_ff} :
                         wr_ipr    ? REG_WDATA[4:0] : ipr_ff;

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    wire is_fetch = (CORE_REQ.kind == dua_pkg::DUA_FETCH);
    wire is_user  = (CORE_REQ.kind == dua_pkg::DUA_USER);
    wire is_data  = (CORE_REQ.kind == dua_pkg::DUA_DATA);

    wire [3:0] data_page = dps_eff ? dpr_ff : cpr_ff;

    // user address: page, base offset, ORed word field
    wire [15:0] user_addr = {ubr_ff[15:dua_pkg::DUA_UBASE_LO],
                             ubr_ff[5:1] | CORE_REQ.ufield,
                             1'b0};

    wire [3:0] sel_page = is_fetch ? cpr_ff :
                          is_user  ? upr_ff[dua_pkg::DUA_PAGE_W-1:0] :
                          data_page;
    wire [15:0] sel_addr = is_user ? user_addr : CORE_REQ.addr;
    wire [19:0] full_addr = {sel_page, sel_addr};

    // ------------------------------------------------------------
    // byte-lane steering
    // ------------------------------------------------------------
    wire order_bit = cfg_ff[dua_pkg::DUA_ORDER_BIT];
    wire byte_acc  = is_data && CORE_REQ.byte_mode;
    // word swap: order mode flipped again by an odd address
    wire word_swap = is_data && (order_bit ^ CORE_REQ.addr[0]);
    // byte lane: address bit 0 inverted in order mode 1
    wire odd_lane  = CORE_REQ.addr[0] ^ order_bit;

    wire [15:0] wr_word = word_swap ? {CORE_REQ.wdata[7:0], CORE_REQ.wdata[15:8]}
                                    : CORE_REQ.wdata;
    wire [15:0] wr_byte = {CORE_REQ.wdata[7:0], CORE_REQ.wdata[7:0]};
    wire [1:0]  be_byte = odd_lane ? 2'h1 : 2'h2;

    dua_pkg::dua_mem_t nxt_mem;
    always_comb begin
        nxt_mem.waddr   = full_addr[19:1];
        nxt_mem.wdata   = byte_acc ? wr_byte : wr_word;
        nxt_mem.byte_en = byte_acc ? be_byte : 2'h3;
        nxt_mem.rd      = CORE_REQ.valid && !CORE_REQ.write;
        nxt_mem.wr      = CORE_REQ.valid && CORE_REQ.write && !is_fetch;
    end

    dua_pkg::dua_pend_t nxt_pend;
    always_comb begin
        nxt_pend.valid    = CORE_REQ.valid && !CORE_REQ.write;
        nxt_pend.is_byte  = byte_acc;
        nxt_pend.odd_lane = odd_lane;
        nxt_pend.swap     = word_swap;
    end

    // ------------------------------------------------------------
    // read return path
    // ------------------------------------------------------------
    dua_pkg::dua_pend_t tail;
    assign tail = pipe_ff[PIPE_LEN];

    wire [7:0]  rd_lane = tail.odd_lane ? sync2_ff[7:0] : sync2_ff[15:8];
    wire [15:0] rd_byte = {8'h00, rd_lane};
    wire [15:0] rd_word = tail.swap ? {sync2_ff[7:0], sync2_ff[15:8]} : sync2_ff;
    wire [15:0] nxt_rd_data = tail.is_byte ? rd_byte : rd_word;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ibc_ff       <= dua_pkg::DUA_RST_WORD;
            cfg_ff       <= dua_pkg::DUA_RST_WORD;
            cpr_ff       <= dua_pkg::DUA_RST_PAGE;
            dpr_ff       <= dua_pkg::DUA_RST_PAGE;
            ipr_ff       <= 5'h00;
            upr_ff       <= dua_pkg::DUA_RST_PAGE;
            ubr_ff       <= dua_pkg::DUA_RST_WORD;
            last_addr_ff <= 20'h00000;
            rdata_ff     <= dua_pkg::DUA_RST_WORD;
        end else begin
            ibc_ff   <= nxt_ibc;
            cfg_ff   <= wr_cfg ? REG_WDATA : cfg_ff;
            cpr_ff   <= wr_cpr ? REG_WDATA[3:0] : cpr_ff;
            dpr_ff   <= wr_dpr ? REG_WDATA[3:0] : dpr_ff;
            ipr_ff   <= nxt_ipr;
            upr_ff   <= wr_upr ? REG_WDATA[3:0] : upr_ff;
            ubr_ff   <= wr_ubr ? REG_WDATA : ubr_ff;
            if (CORE_REQ.valid) begin
                last_addr_ff <= full_addr;
            end
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mem_ff      <= '0;
            rd_data_ff  <= dua_pkg::DUA_RST_WORD;
            rd_valid_ff <= 1'b0;
            for (int i = 0; i <= PIPE_LEN; i++) begin
                pipe_ff[i] <= '0;
            end
        end else begin
            mem_ff     <= nxt_mem;
            pipe_ff[0] <= nxt_pend;
            for (int i = 1; i <= PIPE_LEN; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
            rd_valid_ff <= tail.valid;
            if (tail.valid) begin
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    // memory data come from pins
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sync1_ff <= dua_pkg::DUA_RST_WORD;
            sync2_ff <= dua_pkg::DUA_RST_WORD;
        end else begin
            sync1_ff <= MEM_RDATA;
            sync2_ff <= sync1_ff;
        end
    end

    assign REG_RDATA = rdata_ff;
    assign MEM_OUT   = mem_ff;
    assign RD_DATA   = rd_data_ff;
    assign RD_VALID  = rd_valid_ff;

endmodule : dua_top

// ---- test/dua_mem_model.sv ----
// word-wide external memory answering the block's memory strobes
// assumes the read data are wanted one cycle after the strobe cycle
`timescale 1ns/10ps

module dua_mem_model (
    input  wire logic              CLOCK,
    input  wire dua_pkg::dua_mem_t MEM_OUT,
    output logic      [15:0]       MEM_RDATA
);
    logic [15:0] mem [256];
    wire  [7:0]  idx = {MEM_OUT.waddr[18:15], MEM_OUT.waddr[3:0]};

    initial MEM_RDATA = 16'h0000;

    // ------------------------------------------------------------
    // lane writes and one-cycle read answer
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (MEM_OUT.wr && MEM_OUT.byte_en[1]) mem[idx][15:8] <= MEM_OUT.wdata[15:8];
        if (MEM_OUT.wr && MEM_OUT.byte_en[0]) mem[idx][7:0] <= MEM_OUT.wdata[7:0];
        // bus released outside the answer cycle: show a changing value
        MEM_RDATA <= MEM_OUT.rd ? mem[idx] : ~MEM_RDATA;
    end
endmodule : dua_mem_model

// ---- test/dua_top_assertions.sv ----
// port-level checks of address formation and byte steering
// assumes register writes are the only source of page and order values
`timescale 1ns/10ps

module dua_chk #(
    parameter int MEM_LAT = 1
) (
    input wire logic              CLOCK,
    input wire logic              RST,
    input wire logic [2:0]        REG_ADDR,
    input wire logic [15:0]       REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [15:0]       REG_RDATA,
    input wire dua_pkg::dua_req_t CORE_REQ,
    input wire logic              CORE_RET,
    input wire logic              DPS_SET,
    input wire logic              DPS_CLR,
    input wire logic              RD_VALID,
    input wire dua_pkg::dua_mem_t MEM_OUT
);
    localparam int RD_LAT = 4 + MEM_LAT;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic        order_ff;
    logic [3:0]  cpr_ff, dpr_ff, upr_ff;
    logic [15:0] ubr_ff;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            {order_ff, cpr_ff, dpr_ff, upr_ff, ubr_ff} <= '0;
        end else if (REG_WR) begin
            case (REG_ADDR)
                dua_pkg::DUA_OFF_CFG: order_ff <= REG_WDATA[2];
                dua_pkg::DUA_OFF_CPR: cpr_ff <= REG_WDATA[3:0];
                dua_pkg::DUA_OFF_DPR: dpr_ff <= REG_WDATA[3:0];
                dua_pkg::DUA_OFF_UPR: upr_ff <= REG_WDATA[3:0];
                dua_pkg::DUA_OFF_UBR: ubr_ff <= REG_WDATA;
                default: ;
            endcase
        end
    end
    wire        dat  = CORE_REQ.valid && CORE_REQ.kind == dua_pkg::DUA_DATA;
    wire        usr  = CORE_REQ.valid && CORE_REQ.kind == dua_pkg::DUA_USER;
    wire        fet  = CORE_REQ.valid && CORE_REQ.kind == dua_pkg::DUA_FETCH;
    wire        wr   = CORE_REQ.write;
    wire        bm   = CORE_REQ.byte_mode;
    wire [15:0] w    = CORE_REQ.wdata;
    wire        odd  = order_ff ^ CORE_REQ.addr[0];
    wire [15:0] wexp = odd ? {w[7:0], w[15:8]} : w;
    wire [1:0]  bexp = odd ? 2'h1 : 2'h2;
    wire [18:0] fexp = {cpr_ff, CORE_REQ.addr[15:1]};
    wire [18:0] dexp = {dpr_ff, CORE_REQ.addr[15:1]};
    wire [18:0] uexp = {upr_ff, ubr_ff[15:6], ubr_ff[5:1] | CORE_REQ.ufield};

    word_swap_a: assert property (dat && wr && !bm |=> MEM_OUT.wr && MEM_OUT.wdata == $past(wexp))
        else $error("word lane order wrong");
    byte_lane_a: assert property (dat && wr && bm |=> MEM_OUT.byte_en == $past(bexp)
        && MEM_OUT.wdata == {2{$past(w[7:0])}}) else $error("byte lane wrong");
    user_addr_a: assert property (usr |=> MEM_OUT.waddr == $past(uexp))
        else $error("user address wrong");
    user_word_a: assert property (usr && wr |=> MEM_OUT.wdata == $past(w) && MEM_OUT.byte_en == 2'h3)
        else $error("user write steered");
    fetch_page_a: assert property (fet |=> !MEM_OUT.wr && MEM_OUT.waddr == $past(fexp))
        else $error("fetch address wrong");
    read_lat_a: assert property (dat && !wr |-> ##[RD_LAT:RD_LAT] RD_VALID)
        else $error("read result missing");
    set_page_a: assert property ((DPS_SET && !CORE_RET) ##1 dat |=> MEM_OUT.waddr == $past(dexp))
        else $error("data page not used");
    clr_page_a: assert property ((DPS_CLR && !DPS_SET && !CORE_RET) ##1 dat
        |=> MEM_OUT.waddr == $past(fexp)) else $error("code page not used");
    cfg_read_a: assert property (REG_RD && REG_ADDR == dua_pkg::DUA_OFF_CFG
        |=> REG_RDATA[2] == $past(order_ff)) else $error("order bit read wrong");

    cover property (usr && wr);
    cover property (dat && bm && !wr);
    cover property (CORE_RET);
endmodule : dua_chk

bind dua_top dua_chk #(.MEM_LAT(MEM_LAT)) u_dua_chk (.CLOCK(CLOCK), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CORE_REQ(CORE_REQ), .CORE_RET(CORE_RET), .DPS_SET(DPS_SET),
    .DPS_CLR(DPS_CLR), .RD_VALID(RD_VALID), .MEM_OUT(MEM_OUT));

// ---- test/tb_dua_top.sv ----
// random write/read-back of data and user accesses, plus call/return select
// assumes the memory model answers one cycle after each read strobe
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] %0t value mismatch", $time); end end

module tb_dua_top;
    logic clock, rst, reg_wr, reg_rd, call, ret, dset, dclr, rd_valid;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_data, mem_rdata, d, a, w, m;
    dua_pkg::dua_req_t req_q;
    dua_pkg::dua_mem_t mem_out;
    logic [15:0] exp_mem [256];
    logic [3:0] code_page_reg, data_page_reg, user_page_reg, pg;
    logic [15:0] user_base_reg;
    logic [4:0] uf;
    logic order, sel;
    int n_errors = 0, checks_done = 0;

    dua_top #(.MEM_LAT(1)) u_dua_top (.CLOCK(clock), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CORE_REQ(req_q), .CORE_CALL(call), .CORE_RET(ret), .DPS_SET(dset), .DPS_CLR(dclr),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .MEM_OUT(mem_out), .MEM_RDATA(mem_rdata));
    dua_mem_model u_dua_mem_model (.CLOCK(clock), .MEM_OUT(mem_out), .MEM_RDATA(mem_rdata));

    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end

    function automatic logic [15:0] swp(input logic [15:0] v, input logic s);
        return s ? {v[7:0], v[15:8]} : v;
    endfunction : swp

    // byte read result: chosen lane, upper byte cleared
    function automatic logic [15:0] lane(input logic [15:0] v, input logic odd);
        return {8'h00, odd ? v[7:0] : v[15:8]};
    endfunction : lane

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic wr_reg(input logic [2:0] ad, input logic [15:0] v);
        @(posedge clock) {reg_addr, reg_wdata, reg_wr} <= {ad, v, 1'b1};
        @(posedge clock) reg_wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] ad);
        @(posedge clock) {reg_addr, reg_rd} <= {ad, 1'b1};
        @(posedge clock) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd_reg

    task automatic req(input dua_pkg::dua_kind_t k, input logic wr, bm, input logic [15:0] v);
        @(posedge clock) begin
            req_q <= dua_pkg::dua_req_t'({1'b1, k, wr, bm, a, uf, v});
            {dset, dclr} <= 2'b00;
        end
        @(posedge clock) req_q.valid <= 1'b0;
    endtask : req

    task automatic rd_get;
        int i;
        for (i = 0; i < 20 && rd_valid !== 1'b1; i++) @(posedge clock) #1;
        if (rd_valid !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        d = rd_data;
    endtask : rd_get

    initial begin
        {rst, reg_wr, reg_rd, call, ret, dset, dclr, reg_addr, reg_wdata} = '0;
        req_q = '0;
        rst = 1'b1;
        void'($urandom(32'h72951cb9));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int it = 0; it < 40; it++) begin
            {order, sel, code_page_reg, data_page_reg, user_page_reg, uf, a, w, m} = 67'({$urandom, $urandom, $urandom});
            user_base_reg = 16'($urandom) & 16'hfffe;
            if (it < 2) {a, order} = {it[0] ? 16'h1001 : 16'h1000, it[0]};
            wr_reg(dua_pkg::DUA_OFF_CFG, {13'h0, order, 2'h0});
            wr_reg(dua_pkg::DUA_OFF_CPR, {12'h0, code_page_reg});
            wr_reg(dua_pkg::DUA_OFF_DPR, {12'h0, data_page_reg});
            wr_reg(dua_pkg::DUA_OFF_UPR, {12'h0, user_page_reg});
            wr_reg(dua_pkg::DUA_OFF_UBR, user_base_reg);
            // select pulse directly ahead of the data write
            @(posedge clock) {dset, dclr} <= {sel, !sel};
            pg = sel ? data_page_reg : code_page_reg;
            req(dua_pkg::DUA_DATA, 1'b1, 1'b0, w);
            exp_mem[{pg, a[4:1]}] = swp(w, order ^ a[0]);
            wr_reg(dua_pkg::DUA_OFF_ADDR, ~a);
            rd_reg(dua_pkg::DUA_OFF_ADDR);
            `CHK(d, a)
            a = a ^ 16'h1;
            req(dua_pkg::DUA_DATA, 1'b1, 1'b1, m);
            if (a[0] ^ order) exp_mem[{pg, a[4:1]}][7:0] = m[7:0];
            else exp_mem[{pg, a[4:1]}][15:8] = m[7:0];
            req(dua_pkg::DUA_DATA, 1'b0, 1'b0, 16'h0);
            rd_get();
            `CHK(d, swp(exp_mem[{pg, a[4:1]}], order ^ a[0]))
            req(dua_pkg::DUA_DATA, 1'b0, 1'b1, 16'h0);
            rd_get();
            `CHK(d, lane(exp_mem[{pg, a[4:1]}], a[0] ^ order))
            req(dua_pkg::DUA_USER, 1'b1, 1'b1, w);
            exp_mem[{user_page_reg, user_base_reg[4:1] | uf[3:0]}] = w;
            req(dua_pkg::DUA_USER, 1'b0, 1'b1, 16'h0);
            rd_get();
            `CHK(d, w)
            req(dua_pkg::DUA_FETCH, 1'b1, 1'b0, w);
        end
        @(posedge clock) dset <= 1'b1;
        @(posedge clock) {dset, call} <= 2'b01;
        @(posedge clock) call <= 1'b0;
        rd_reg(dua_pkg::DUA_OFF_CFG);
        `CHK(d[2], order)
        rd_reg(dua_pkg::DUA_OFF_IPR);
        `CHK(d[4:0], {1'b1, code_page_reg})
        wr_reg(dua_pkg::DUA_OFF_IPR, 16'h0000);
        @(posedge clock) ret <= 1'b1;
        @(posedge clock) ret <= 1'b0;
        rd_reg(dua_pkg::DUA_OFF_IBC);
        `CHK(d[5], 1'b0)
        wr_reg(dua_pkg::DUA_OFF_IBC, 16'h0020);
        rd_reg(dua_pkg::DUA_OFF_IBC);
        `CHK(d[5], 1'b1)
        report_and_stop();
    end
endmodule : tb_dua_top
